// ===== host_sink.sv
`timescale 1ns/1ps

// ****
// Host side sink for the replayed stream
// ****
module host_sink
  import position_fix_batch_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic out_valid,
  input wire logic out_is_status,
  input wire logic [FIX_W-1:0] out_data,
  input wire logic [1:0] mode,
  output logic out_ready
);
  logic [FIX_W:0] words [0:63];
  int n;
  logic [1:0] tick;

  // Mode 0 takes every word, 1 one cycle in four, 2 stalls; no other traffic competes
  always @(posedge mclk)
  begin
    if (rst)
    begin
      n <= 0;
      tick <= 2'h0;
      out_ready <= 1'b0;
    end
    else
    begin
      if (out_valid && out_ready)
      begin
        words[n[5:0]] <= {out_is_status, out_data};
        n <= n + 1;
      end
      tick <= tick + 2'h1;
      out_ready <= (mode == 2'h0) || (mode == 2'h1 && tick == 2'h3);
    end
  end
endmodule // host_sink

// ===== position_fix_batch_buffer.sv
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps

// ****************************************
// Output FIFO
// ****************************************
module position_fix_batch_fifo
  import position_fix_batch_pkg::*;
#(
  parameter int W = 33,
  parameter int DEPTH = 16
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW:0] cnt;
  } fifo_s;

  fifo_s f_reg;
  fifo_s f_next;
  logic [W-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // Pointer arithmetic wraps only on a power of two
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("FIFO depth must be a power of two of at least 2");
  end

  // Handshakes straight from the occupancy count
  assign in_ready = f_reg.cnt != (AW+1)'(DEPTH);
  assign out_valid = f_reg.cnt != '0;
  assign out_data = mem[f_reg.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Next pointers and count
  always_comb
  begin
    f_next = f_reg;
    if (push)
      f_next.wr = f_reg.wr + 1'b1;
    if (pop)
      f_next.rd = f_reg.rd + 1'b1;
    if (push && !pop)
      f_next.cnt = f_reg.cnt + 1'b1;
    else if (pop && !push)
      f_next.cnt = f_reg.cnt - 1'b1;
  end

  // State register
  always_ff @(posedge mclk)
  begin
    if (rst)
      f_reg <= '0;
    else
      f_reg <= f_next;
  end

  // Storage needs no reset; only counted words are ever read
  always_ff @(posedge mclk)
  begin
    if (push)
      mem[f_reg.wr] <= in_data;
  end
endmodule // position_fix_batch_fifo

// Behaviour
// - Batching off after reset; storing needs enable and nonzero capacity.
// - Flag pin rises when stored count reaches notify level; host keeps level within capacity.
// - Full buffer drops oldest fix and keeps newest, as an overwriting ring.
// - Capacity limit is 300, 221 odometer, 156 extended, 132 both.
// - Configuration exceeding memory is rejected and not applied.
// - Capacity counts epochs; one entry per navigation solution.
// - Disabling clears all entries; host keeps batching enabled during readout.
// - Readout goes oldest to newest with no skipping.
// - Readout request sends every held fix, one batch entry message each.
// - With status-first option, fill status report precedes the entries.
// - Readout request during an ongoing readout is silently discarded.
// - No acknowledgment for a readout request; replies alone answer it.
// - Fill status report carries fill level and overrun drop count.
// - Storing continues autonomously whatever the host is doing.
module position_fix_batch_buffer
  import position_fix_batch_pkg::*;
#(
  parameter int MEM_EPOCHS = MAX_EPOCHS,
  parameter int OUT_DEPTH = FIFO_DEPTH
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fix_valid,
  input wire logic [FIX_W-1:0] fix_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic out_is_status,
  output logic [FIX_W-1:0] out_data,
  output logic fill_flag
);
  // ****************************************
  // Declarations
  // ****************************************
  state_s st_reg;
  state_s st_next;
  logic [FIX_W-1:0] mem [MEM_EPOCHS];
  logic wr_acc;
  logic rd_setup;
  logic mapped;
  logic active;
  logic full;
  logic store;
  logic pop;
  logic overwrite;
  logic mem_we;
  logic [CNT_W-1:0] mem_wa;
  logic [CNT_W-1:0] wcap;
  logic [CNT_W-1:0] req_cap;
  logic req_ok;
  logic rd_req;
  logic fifo_valid;
  logic fifo_ready;
  out_word_s fifo_in;
  out_word_s fifo_out;

  // All checks below sample on the system clock; all but off_after_reset_a sleep through reset
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // Ring needs room for the largest documented capacity
  if (MEM_EPOCHS < MAX_EPOCHS || MEM_EPOCHS >= (1 << CNT_W))
  begin : g_bad_mem
    $error("MEM_EPOCHS must hold the full epoch limit and fit the counters");
  end

  // Ring index wrap at the programmed capacity
  function automatic logic [CNT_W-1:0] wrap(input logic [CNT_W:0] x, input logic [CNT_W-1:0] cap);
    logic [CNT_W:0] r;
    r = x;
    if (x >= {1'b0, cap})
      r = x - {1'b0, cap};
    return r[CNT_W-1:0];
  endfunction

  // ****************************************
  // APB decode
  // ****************************************
  // Zero wait states; unmapped offsets answer with pslverr
  assign pready = 1'b1;
  assign mapped = paddr == OFF_CFG || paddr == OFF_NOTIFY || paddr == OFF_READOUT
                  || paddr == OFF_STATUS || paddr == OFF_DROPPED;
  assign pslverr = psel && penable && !mapped;
  assign wr_acc = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;
  assign prdata = st_reg.rdata;
  assign req_cap = pwdata[CFG_CAP_LSB +: CNT_W];
  assign req_ok = req_cap <= epoch_limit(pwdata[CFG_EXT_BIT], pwdata[CFG_ODO_BIT]);
  // A request while busy is dropped and nothing answers it
  assign rd_req = wr_acc && paddr == OFF_READOUT && pwdata[RD_GO_BIT];

  // ****************************************
  // Ring bookkeeping
  // ****************************************
  // Fixes store on their own strobe, no host action needed
  assign active = st_reg.cfg_en && st_reg.cap != '0;
  assign wcap = st_reg.cap;
  assign full = st_reg.count == st_reg.cap;
  assign store = fix_valid && active;
  assign pop = st_reg.fsm == ST_DRAIN && st_reg.remain != '0 && st_reg.count != '0 && fifo_ready;
  assign overwrite = store && full && !pop;
  assign mem_we = store;
  assign mem_wa = overwrite ? st_reg.head : wrap({1'b0, st_reg.head} + {1'b0, st_reg.count}, wcap);
  assign fill_flag = st_reg.fill_flag;

  // Output word: status report or oldest entry
  always_comb
  begin
    fifo_in.is_status = st_reg.fsm == ST_STAT;
    fifo_in.data = mem[st_reg.head];
    if (st_reg.fsm == ST_STAT)
      fifo_in.data = {st_reg.dropped, {(16 - CNT_W){1'b0}}, st_reg.count};
  end
  assign fifo_valid = st_reg.fsm == ST_STAT || pop;

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    st_next = st_reg;
    // Ring pointers: overwrite advances head, pop advances head too
    if (pop)
      st_next.head = wrap({1'b0, st_reg.head} + 1'b1, wcap);
    if (overwrite)
    begin
      st_next.head = wrap({1'b0, st_reg.head} + 1'b1, wcap);
      st_next.dropped = st_reg.dropped + 1'b1;
    end
    if (store && !full && !pop)
      st_next.count = st_reg.count + 1'b1;
    else if (pop && !store)
      st_next.count = st_reg.count - 1'b1;
    // Readout sequencer
    case (st_reg.fsm)
      ST_IDLE:
        if (rd_req)
        begin
          st_next.remain = st_reg.count;
          st_next.fsm = pwdata[RD_SF_BIT] ? ST_STAT : ST_DRAIN;
        end
      ST_STAT:
        if (fifo_ready)
          st_next.fsm = ST_DRAIN;
      ST_DRAIN:
        if (pop)
          st_next.remain = st_reg.remain - 1'b1;
        else if (st_reg.remain == '0 || st_reg.count == '0)
          st_next.fsm = ST_IDLE;
      default:
        st_next.fsm = ST_IDLE;
    endcase
    // Requests in STAT or DRAIN fall through untouched
    // Register writes; a refused configuration leaves the old one
    if (wr_acc && paddr == OFF_CFG)
    begin
      st_next.cfg_err = !req_ok;
      if (req_ok)
      begin
        st_next.cfg_en = pwdata[CFG_EN_BIT];
        st_next.cfg_ext = pwdata[CFG_EXT_BIT];
        st_next.cfg_odo = pwdata[CFG_ODO_BIT];
        st_next.cap = req_cap;
        // Any applied change restarts the ring, so old layout never mixes in
        st_next.head = CNT_RESET;
        st_next.count = CNT_RESET;
        st_next.remain = CNT_RESET;
        st_next.dropped = DROP_RESET;
      end
    end
    // Level beyond capacity is never reached, so it cannot flag
    if (wr_acc && paddr == OFF_NOTIFY)
      st_next.notify = pwdata[CNT_W-1:0];
    st_next.fill_flag = active && st_next.notify != '0 && st_next.count >= st_next.notify;
    // Read data captured in setup so it stands through the access phase
    st_next.rdata = 32'h0000_0000;
    if (rd_setup)
      case (paddr)
        OFF_CFG:
        begin
          st_next.rdata[CFG_EN_BIT] = st_reg.cfg_en;
          st_next.rdata[CFG_EXT_BIT] = st_reg.cfg_ext;
          st_next.rdata[CFG_ODO_BIT] = st_reg.cfg_odo;
          st_next.rdata[CFG_CAP_LSB +: CNT_W] = st_reg.cap;
        end
        OFF_NOTIFY: st_next.rdata[CNT_W-1:0] = st_reg.notify;
        OFF_STATUS:
        begin
          st_next.rdata[CNT_W-1:0] = st_reg.count;
          st_next.rdata[ST_BUSY_BIT] = st_reg.fsm != ST_IDLE;
          st_next.rdata[ST_ERR_BIT] = st_reg.cfg_err;
          st_next.rdata[ST_ACT_BIT] = active;
        end
        OFF_DROPPED: st_next.rdata[15:0] = st_reg.dropped;
        default: st_next.rdata = 32'h0000_0000;
      endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  // Reset leaves batching disabled and the ring empty
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_reg <= '0;
      st_reg.fsm <= ST_IDLE;
    end
    else
      st_reg <= st_next;
  end

  // Fix storage, one word per epoch
  always_ff @(posedge mclk)
  begin
    if (mem_we)
      mem[mem_wa] <= fix_data;
  end

  // Output buffer decouples the host port from the ring
  position_fix_batch_fifo #(
    .W(FIX_W + 1),
    .DEPTH(OUT_DEPTH)
  ) u_out_fifo (
    .mclk(mclk),
    .rst(rst),
    .in_valid(fifo_valid),
    .in_ready(fifo_ready),
    .in_data(fifo_in),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(fifo_out)
  );
  assign out_is_status = fifo_out.is_status;
  assign out_data = fifo_out.data;

  // ****************************************
  // Checks
  // ****************************************
  off_after_reset_a: assert property (@(posedge mclk) disable iff (1'b0) rst |=> !active && st_reg.count == '0)
    else $error("batching active after reset");
  fill_flag_a: assert property (active && st_reg.notify != '0 && st_reg.count >= st_reg.notify
      && !$rose(st_reg.count == '0) |-> ##[0:1] fill_flag)
    else $error("fill flag missing at notify level");
  ring_overwrite_a: assert property (overwrite && !wr_acc |=> st_reg.count == $past(st_reg.count)
      && st_reg.dropped == $past(st_reg.dropped) + 16'h0001)
    else $error("full ring did not overwrite oldest");
  cap_limit_a: assert property (st_reg.cap <= epoch_limit(st_reg.cfg_ext, st_reg.cfg_odo)
      && st_reg.count <= st_reg.cap)
    else $error("capacity beyond epoch limit");
  reject_cfg_a: assert property (wr_acc && paddr == OFF_CFG && !req_ok
      |=> st_reg.cfg_err && $stable(st_reg.cap) && $stable(st_reg.cfg_en))
    else $error("oversized configuration applied");
  store_epoch_a: assert property (store && !full && !pop && !wr_acc
      |=> st_reg.count == $past(st_reg.count) + 9'h001)
    else $error("fix not stored");
  disable_clears_a: assert property (wr_acc && paddr == OFF_CFG && req_ok && !pwdata[CFG_EN_BIT]
      |=> st_reg.count == '0 && st_reg.dropped == '0 && !fill_flag)
    else $error("disable left entries");
  oldest_first_a: assert property (pop && !wr_acc |-> fifo_valid && !fifo_in.is_status
      ##1 st_reg.head == wrap({1'b0, $past(st_reg.head)} + 1'b1, wcap))
    else $error("readout not oldest first");
  status_first_a: assert property (st_reg.fsm == ST_IDLE && rd_req && pwdata[RD_SF_BIT]
      |=> st_reg.fsm == ST_STAT && fifo_valid && fifo_in.is_status
      && fifo_in.data[CNT_W-1:0] == st_reg.count)
    else $error("status report not first");
  busy_discard_a: assert property (st_reg.fsm == ST_DRAIN && rd_req |=> st_reg.fsm != ST_STAT
      && st_reg.remain <= $past(st_reg.remain))
    else $error("readout restarted while busy");
  drain_count_a: assert property (st_reg.fsm == ST_IDLE && rd_req && !pwdata[RD_SF_BIT]
      |=> st_reg.fsm == ST_DRAIN && st_reg.remain == $past(st_reg.count))
    else $error("readout did not take all fixes");
endmodule // position_fix_batch_buffer

// ===== position_fix_batch_buffer_tb_top.sv
`timescale 1ns/1ps

module position_fix_batch_buffer_tb_top
  import position_fix_batch_pkg::*;
;
  logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, fix_valid = 0;
  logic out_ready, out_valid, out_is_status, fill_flag, pready, pslverr, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [FIX_W-1:0] fix_data = 32'h0000_0000, out_data;
  logic [1:0] mode = 2'h0;
  logic [CNT_W-1:0] lims [0:3] = '{LIM_BASE, LIM_ODO, LIM_EXT, LIM_BOTH};
  int num_errors = 0, comparisons = 0, cycles = 0, base;

  position_fix_batch_buffer position_fix_batch_buffer_i (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fix_valid(fix_valid), .fix_data(fix_data), .out_valid(out_valid),
    .out_ready(out_ready), .out_is_status(out_is_status), .out_data(out_data), .fill_flag(fill_flag));
  host_sink host_sink_i (.mclk(mclk), .rst(rst), .out_valid(out_valid), .out_is_status(out_is_status),
    .out_data(out_data), .mode(mode), .out_ready(out_ready));

  // Clock and hang guard
  initial forever #20 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      stop_test();
    end
  end

  task automatic stop_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // One APB transfer; one idle cycle separates transfers so no signal is set twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    // Answer taken at the rising edge where pready is seen; only the bench timeout ends a hang
    do
    begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    comparisons++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Fixes arrive back to back, one per epoch
  task automatic fixes(input int k, input int first);
    for (int i = 0; i < k; i++)
    begin
      @(posedge mclk);
      fix_valid <= 1;
      fix_data <= FIX_W'(first + i);
    end
    @(posedge mclk);
    fix_valid <= 0;
  endtask

  function automatic logic [31:0] cfg(input logic en, ext, odo, input logic [CNT_W-1:0] cap);
    cfg = '0;
    cfg[CFG_EN_BIT] = en;
    cfg[CFG_EXT_BIT] = ext;
    cfg[CFG_ODO_BIT] = odo;
    cfg[CFG_CAP_LSB +: CNT_W] = cap;
  endfunction

  // Waits for k words, then lets time pass so any surplus word would show
  task automatic wait_words(input int k);
    int n;
    n = 0;
    while (host_sink_i.n < base + k && n < 3000)
    begin
      @(posedge mclk);
      n++;
    end
    repeat (40) @(posedge mclk);
    chk("word_count", 33'(base + k), 33'(host_sink_i.n));
  endtask

  // Main sequence
  initial
  begin
    repeat (5) @(posedge mclk);
    rst <= 0;
    apb(0, OFF_CFG, 0);
    chk("cfg_reset", 0, 33'(rd));
    fixes(2, 1);
    apb(1, OFF_CFG, cfg(1, 0, 0, 9'h000));
    fixes(3, 1);
    apb(0, OFF_STATUS, 0);
    chk("count_cap0", 0, 33'(rd[8:0]));
    for (int i = 0; i < 4; i++)
    begin
      apb(1, OFF_CFG, cfg(1, i[1], i[0], lims[i] + 9'h001));
      apb(0, OFF_STATUS, 0);
      chk("cfg_reject", 1, 33'(rd[ST_ERR_BIT]));
      apb(1, OFF_CFG, cfg(1, i[1], i[0], lims[i]));
      apb(0, OFF_STATUS, 0);
      chk("cfg_accept", 0, 33'(rd[ST_ERR_BIT]));
      apb(0, OFF_CFG, 0);
      chk("cfg_read", 33'(cfg(1, i[1], i[0], lims[i])), 33'(rd));
    end
    // Ring overwrite, flag and status-first readout to a slow host
    mode <= 2'h1;
    apb(1, OFF_CFG, cfg(1, 0, 0, 9'h004));
    apb(1, OFF_NOTIFY, 32'h0000_0003);
    fixes(3, 1);
    repeat (3) @(posedge mclk);
    chk("flag_at_level", 1, 33'(fill_flag));
    fixes(3, 4);
    apb(0, OFF_STATUS, 0);
    chk("count_full", 4, 33'(rd[8:0]));
    apb(0, OFF_DROPPED, 0);
    chk("dropped", 2, 33'(rd[15:0]));
    base = host_sink_i.n;
    apb(1, OFF_READOUT, 32'h0000_0003);
    apb(1, OFF_READOUT, 32'h0000_0003);
    wait_words(5);
    chk("status_word", {1'b1, 16'h0002, 7'h00, 9'h004}, host_sink_i.words[base]);
    for (int k = 0; k < 4; k++) chk("entry", {1'b0, FIX_W'(k + 3)}, host_sink_i.words[base + 1 + k]);
    chk("flag_after_drain", 0, 33'(fill_flag));
    // Plain readout into a stalled host fills the output buffer
    mode <= 2'h2;
    apb(1, OFF_CFG, cfg(1, 0, 0, 9'h014));
    fixes(20, 16);
    base = host_sink_i.n;
    apb(1, OFF_READOUT, 32'h0000_0001);
    repeat (40) @(posedge mclk);
    chk("stall_valid", 1, 33'(out_valid));
    apb(0, OFF_STATUS, 0);
    chk("stall_busy", 1, 33'(rd[ST_BUSY_BIT]));
    mode <= 2'h0;
    wait_words(20);
    for (int k = 0; k < 20; k++) chk("entry_plain", {1'b0, FIX_W'(16 + k)}, host_sink_i.words[base + k]);
    apb(0, OFF_STATUS, 0);
    chk("status_after", 0, 33'({rd[ST_BUSY_BIT], rd[8:0]}));
    // Disable only after readout has ended, which empties the buffer
    apb(1, OFF_CFG, cfg(1, 0, 0, 9'h002));
    fixes(4, 1);
    apb(1, OFF_CFG, cfg(0, 0, 0, 9'h002));
    apb(0, OFF_STATUS, 0);
    chk("count_disabled", 0, 33'(rd[8:0]));
    apb(0, OFF_DROPPED, 0);
    chk("dropped_disabled", 0, 33'(rd[15:0]));
    apb(0, 8'h14, 0);
    chk("unmapped_err", 1, 33'(err));
    chk("unmapped_rd", 0, 33'(rd));
    stop_test();
  end
endmodule // position_fix_batch_buffer_tb_top

// ===== position_fix_batch_pkg.sv
package position_fix_batch_pkg;

  // ****************************************
  // Widths and limits
  // ****************************************
  localparam int CNT_W = 9;
  localparam int FIX_W = 32;
  localparam int FIFO_DEPTH = 16;
  localparam int MAX_EPOCHS = 300;
  // Epoch limits for the four extra-content combinations
  localparam logic [CNT_W-1:0] LIM_BASE = 9'h12C; // 300
  localparam logic [CNT_W-1:0] LIM_ODO = 9'h0DD; // 221
  localparam logic [CNT_W-1:0] LIM_EXT = 9'h09C; // 156
  localparam logic [CNT_W-1:0] LIM_BOTH = 9'h084; // 132

  // ****************************************
  // Register offsets and fields
  // ****************************************
  localparam logic [7:0] OFF_CFG = 8'h00;
  localparam logic [7:0] OFF_NOTIFY = 8'h04;
  localparam logic [7:0] OFF_READOUT = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_DROPPED = 8'h10;
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_EXT_BIT = 1;
  localparam int CFG_ODO_BIT = 2;
  localparam int CFG_CAP_LSB = 16;
  localparam int RD_GO_BIT = 0;
  localparam int RD_SF_BIT = 1;
  localparam int ST_BUSY_BIT = 16;
  localparam int ST_ERR_BIT = 17;
  localparam int ST_ACT_BIT = 18;
  localparam int REP_DROP_LSB = 16;
  localparam logic [CNT_W-1:0] CNT_RESET = 9'h000;
  localparam logic [15:0] DROP_RESET = 16'h0000;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_STAT = 3'b010,
    ST_DRAIN = 3'b100
  } fsm_e;

  typedef struct packed {
    logic is_status;
    logic [FIX_W-1:0] data;
  } out_word_s;

  typedef struct packed {
    logic cfg_en;
    logic cfg_ext;
    logic cfg_odo;
    logic [CNT_W-1:0] cap;
    logic [CNT_W-1:0] notify;
    logic cfg_err;
    logic [CNT_W-1:0] head;
    logic [CNT_W-1:0] count;
    logic [15:0] dropped;
    fsm_e fsm;
    logic [CNT_W-1:0] remain;
    logic fill_flag;
    logic [31:0] rdata;
  } state_s;

  // Largest capacity that memory can hold for the chosen content
  function automatic logic [CNT_W-1:0] epoch_limit(input logic ext, input logic odo);
    case ({ext, odo})
      2'b00: epoch_limit = LIM_BASE;
      2'b01: epoch_limit = LIM_ODO;
      2'b10: epoch_limit = LIM_EXT;
      default: epoch_limit = LIM_BOTH;
    endcase
  endfunction

endpackage
